/* File: core/usb_host_tx_dma_descriptor_engine.sv */
// host transmit endpoints 0..4 with a descriptor-chain dma feeding endpoints 1..4
// assumes apb master, a word memory port that acks one word at a time in a burst, gaps allowed,
// and a link that reports each sent packet on sent_valid, all on clk
`timescale 1ns/100ps
module usb_host_tx_dma_descriptor_engine #(
  parameter int unsigned FRAME_CYCLES = utd_pkg::FRAME_TIME_US * utd_pkg::CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [6:0] mem_blen,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic fifo_wr,
  output logic [2:0] fifo_ep,
  output logic [31:0] fifo_data,
  output logic [2:0] fifo_nbytes,
  output logic fifo_commit,
  output logic [3:0] dma_req,
  output logic tok_valid,
  output logic [2:0] tok_ep,
  output logic [6:0] tok_func_addr,
  output logic [7:0] tok_type,
  input wire logic sent_valid,
  input wire logic [2:0] sent_ep,
  input wire logic sent_err,
  output logic [4:0] ep_irq,
  output logic sof_pulse
);
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      {rst_s1_r, rst_n} <= 2'h0;
    else
      {rst_s1_r, rst_n} <= {1'b1, rst_s1_r};

  logic [6:0] func_r [5];
  logic [7:0] type_r [5];
  logic [10:0] maxp_r [5];
  logic [7:0] intv_r [5];
  logic [15:0] ctl_r [5];
  logic [4:0] fifosz_r [5];
  logic [4:0] ien_r;
  logic [3:0] mode_r;
  logic [31:0] head_r [4];
  logic [1:0] pcnt_r [5];
  logic err_r [5];
  logic [1:0] cap [5];
  logic [4:0] rdy_mask;
  utd_pkg::dma_state_t st_r;
  logic [1:0] ch_r;
  logic [1:0] widx_r;
  logic [31:0] desc_r;
  logic [31:0] first_r;
  logic [31:0] nxt_r;
  logic [31:0] buf_r;
  logic [31:0] w2_r;
  logic [31:0] w3_r;
  logic [31:0] firstw3_r;
  logic [15:0] rem_r;
  logic [6:0] bcnt_r;
  logic [10:0] pbytes_r;

  // apb: one wait state so that read data comes from a flop
  wire apb_acc = psel & penable & ~pready;
  wire apb_wr = psel & penable & pwrite & pready;
  wire [2:0] a_ep = paddr[7:5];
  wire [4:0] a_rg = paddr[4:0];
  wire ep_hit = (paddr[11:8] == 4'h0) & (a_ep < 3'h5) & (a_rg <= utd_pkg::OFS_FIFOSZ)
    & (a_rg[1:0] == 2'h0);
  wire [2:0] ep_ix = ep_hit ? a_ep : 3'h0;
  wire irq_hit = paddr[11:2] == utd_pkg::OFS_IRQ_EN[11:2];
  wire head_hit = paddr[11:4] == utd_pkg::OFS_HEAD0[11:4];
  wire mode_hit = paddr[11:2] == utd_pkg::OFS_MODE[11:2];
  wire hit = ep_hit | irq_hit | head_hit | mode_hit;
  wire [1:0] a_ch = paddr[3:2];
  wire ep_wr = apb_wr & ep_hit;
  wire csr_wr = ep_wr & (a_rg == utd_pkg::OFS_CSR);
  wire [2:0] dma_ep = {1'b0, ch_r} + 3'h1;
  wire [15:0] csr_rd = (ctl_r[ep_ix] & utd_pkg::CSR_RW_MASK)
    | {13'h0, err_r[ep_ix], pcnt_r[ep_ix] != 2'h0, pcnt_r[ep_ix] != 2'h0};

  logic [31:0] rd_nxt;
  always_comb
  begin
    rd_nxt = 32'h0;
    if (ep_hit)
      case (a_rg)
        utd_pkg::OFS_FUNC: rd_nxt = {25'h0, func_r[ep_ix]};
        utd_pkg::OFS_TYPE: rd_nxt = {24'h0, type_r[ep_ix]};
        utd_pkg::OFS_MAXP: rd_nxt = {21'h0, maxp_r[ep_ix]};
        utd_pkg::OFS_INTV: rd_nxt = {24'h0, intv_r[ep_ix]};
        utd_pkg::OFS_CSR: rd_nxt = {16'h0, csr_rd};
        default: rd_nxt = {27'h0, fifosz_r[ep_ix]};
      endcase
    else if (irq_hit)
      rd_nxt = {27'h0, ien_r};
    else if (head_hit)
      rd_nxt = head_r[a_ch];
    else if (mode_hit)
      rd_nxt = {28'h0, mode_r};
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~hit;
      prdata <= apb_acc & ~pwrite ? rd_nxt : 32'h0;
    end

  // endpoint setup registers, written only by software
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      for (int i = 0; i < utd_pkg::NUM_EP; i++)
      begin
        func_r[i] <= 7'h0;
        type_r[i] <= 8'h0;
        maxp_r[i] <= utd_pkg::RST_MAXP;
        intv_r[i] <= 8'h0;
        ctl_r[i] <= utd_pkg::RST_CSR;
        fifosz_r[i] <= utd_pkg::RST_FIFOSZ;
      end
      ien_r <= 5'h0;
      mode_r <= 4'h0;
    end
    else
    begin
      if (ep_wr)
        case (a_rg)
          utd_pkg::OFS_FUNC: func_r[ep_ix] <= pwdata[6:0];
          utd_pkg::OFS_TYPE: type_r[ep_ix] <= pwdata[7:0];
          utd_pkg::OFS_MAXP: maxp_r[ep_ix] <= pwdata[10:0];
          utd_pkg::OFS_INTV: intv_r[ep_ix] <= pwdata[7:0];
          utd_pkg::OFS_CSR: ctl_r[ep_ix] <= pwdata[15:0] & utd_pkg::CSR_RW_MASK;
          default: fifosz_r[ep_ix] <= pwdata[4:0];
        endcase
      if (apb_wr & irq_hit)
        ien_r <= pwdata[4:0];
      if (apb_wr & mode_hit)
        mode_r <= pwdata[3:0];
    end

  // fifo occupancy per endpoint; force toggle is stored but never consulted
  for (genvar e = 0; e < utd_pkg::NUM_EP; e++)
  begin : g_ep
    wire dma_on = ctl_r[e][utd_pkg::CSR_DMA_EN_BIT];
    wire quiet = dma_on & ctl_r[e][utd_pkg::CSR_SUPPRESS_BIT];
    wire sent_here = sent_valid & (sent_ep == e);
    wire inc = (csr_wr & (ep_ix == e) & pwdata[utd_pkg::CSR_PKT_READY_BIT])
      | (fifo_commit & (fifo_ep == e));
    wire dec = sent_here & (pcnt_r[e] != 2'h0);
    assign cap[e] = fifosz_r[e][utd_pkg::FIFOSZ_DBL_BIT] ? 2'h2 : 2'h1;
    assign rdy_mask[e] = pcnt_r[e] != 2'h0;
    always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
        pcnt_r[e] <= 2'h0;
        err_r[e] <= 1'b0;
        ep_irq[e] <= 1'b0;
      end
      else
      begin
        if (inc & ~dec & (pcnt_r[e] < cap[e]))
          pcnt_r[e] <= pcnt_r[e] + 2'h1;
        else if (dec & ~inc)
          pcnt_r[e] <= pcnt_r[e] - 2'h1;
        // a link error in the clearing cycle still sticks
        if (sent_here & sent_err)
          err_r[e] <= 1'b1;
        else if (csr_wr & (ep_ix == e) & ~pwdata[utd_pkg::CSR_ERROR_BIT])
          err_r[e] <= 1'b0;
        ep_irq[e] <= ien_r[e] & sent_here & (sent_err | ~quiet);
      end
    AST_CAP: assert property (@(posedge clk) disable iff (!rst_n)
      pcnt_r[e] <= cap[e])
      else $error("fifo holds more packets than its buffering allows");
    AST_SUPPRESS: assert property (@(posedge clk) disable iff (!rst_n)
      ep_irq[e] && $past(quiet) |-> $past(sent_err))
      else $error("suppressed endpoint interrupted without an error");
    AST_SENT_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
      sent_here && ien_r[e] && !quiet |=> ep_irq[e])
      else $error("sent packet raised no endpoint interrupt");
  end

  // frame timer and one out token per ready endpoint each frame
  logic [31:0] frm_r;
  logic [4:0] pend_r;
  logic iss_v;
  logic [2:0] iss_ep;
  always_comb
  begin
    iss_v = 1'b0;
    iss_ep = 3'h0;
    for (int i = utd_pkg::NUM_EP - 1; i >= 0; i--)
      if (pend_r[i] & rdy_mask[i])
      begin
        iss_v = 1'b1;
        iss_ep = 3'(i);
      end
  end
  wire frame_end = frm_r == FRAME_CYCLES - 1;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      frm_r <= 32'h0;
      sof_pulse <= 1'b0;
      pend_r <= 5'h0;
      tok_valid <= 1'b0;
      tok_ep <= 3'h0;
      tok_func_addr <= 7'h0;
      tok_type <= 8'h0;
    end
    else
    begin
      frm_r <= frame_end ? 32'h0 : frm_r + 32'h1;
      sof_pulse <= frame_end;
      tok_valid <= iss_v;
      tok_ep <= iss_ep;
      tok_func_addr <= func_r[iss_ep];
      tok_type <= type_r[iss_ep];
      if (frame_end)
        pend_r <= rdy_mask;
      else if (iss_v)
        pend_r[iss_ep] <= 1'b0;
    end

  // dma channel c serves endpoint c+1; endpoint 0 has none
  logic pick_v;
  logic [1:0] pick;
  always_comb
  begin
    pick_v = 1'b0;
    pick = 2'h0;
    for (int c = utd_pkg::NUM_CH - 1; c >= 0; c--)
      if (dma_req[c] & (head_r[c] != 32'h0))
      begin
        pick_v = 1'b1;
        pick = 2'(c);
      end
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      dma_req <= 4'h0;
    else
      for (int c = 0; c < utd_pkg::NUM_CH; c++)
        dma_req[c] <= ctl_r[c + 1][utd_pkg::CSR_DMA_EN_BIT] & (pcnt_r[c + 1] < cap[c + 1]);

  // the dma side wins a head pointer collision with software
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      for (int c = 0; c < utd_pkg::NUM_CH; c++)
        head_r[c] <= utd_pkg::RST_HEAD;
    else if (st_r == utd_pkg::D_NEXT)
      head_r[ch_r] <= nxt_r;
    else if (apb_wr & head_hit)
      head_r[a_ch] <= {pwdata[31:2], 2'h0};

  wire [2:0] nb = rem_r < 16'h4 ? rem_r[2:0] : 3'h4;
  wire [6:0] blen = rem_r < 16'h40 ? rem_r[6:0] : utd_pkg::MAX_BURST;
  wire net_mode = mode_r[ch_r];
  wire net_cut = net_mode & (pbytes_r + {8'h0, nb} == maxp_r[dma_ep]);
  wire last_cmt = ~net_mode | (pbytes_r != 11'h0);
  wire qend_first = (nxt_r == 32'h0) & (first_r == desc_r);
  wire qend_cur = (nxt_r == 32'h0) & (first_r != desc_r);
  wire [31:0] wb_first = (firstw3_r & ~(32'h1 << utd_pkg::D3_OWNER))
    | ({31'h0, qend_first} << utd_pkg::D3_QEND);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      st_r <= utd_pkg::D_IDLE;
      {ch_r, widx_r, bcnt_r, rem_r, pbytes_r} <= 38'h0;
      {desc_r, first_r, nxt_r, buf_r} <= 128'h0;
      {w2_r, w3_r, firstw3_r} <= 96'h0;
      {mem_req, mem_we, mem_blen} <= 9'h0;
      {mem_addr, mem_wdata, fifo_data} <= 96'h0;
      {fifo_wr, fifo_ep, fifo_nbytes, fifo_commit} <= 8'h0;
    end
    else
    begin
      fifo_wr <= 1'b0;
      fifo_commit <= 1'b0;
      unique case (st_r)
        utd_pkg::D_IDLE:
          if (pick_v)
          begin
            ch_r <= pick;
            desc_r <= head_r[pick];
            {mem_req, mem_we, mem_addr, mem_blen} <= {2'h2, head_r[pick], utd_pkg::DESC_BYTES};
            widx_r <= 2'h0;
            st_r <= utd_pkg::D_DESC;
          end
        utd_pkg::D_DESC:
          if (mem_ack)
          begin
            widx_r <= widx_r + 2'h1;
            case (widx_r)
              2'h0: nxt_r <= mem_rdata;
              2'h1: buf_r <= mem_rdata;
              2'h2: w2_r <= mem_rdata;
              default:
              begin
                w3_r <= mem_rdata;
                mem_req <= 1'b0;
                rem_r <= w2_r[15:0];
                if (mem_rdata[utd_pkg::D3_FIRST])
                begin
                  first_r <= desc_r;
                  firstw3_r <= mem_rdata;
                  pbytes_r <= 11'h0;
                  buf_r <= buf_r + {16'h0, w2_r[31:16]};
                end
                // a packet software still owns is left alone and polled again
                if (mem_rdata[utd_pkg::D3_FIRST] & ~mem_rdata[utd_pkg::D3_OWNER])
                  st_r <= utd_pkg::D_IDLE;
                else
                  st_r <= utd_pkg::D_DATA;
              end
            endcase
          end
        utd_pkg::D_DATA:
          if (!mem_req)
          begin
            if (rem_r != 16'h0)
            begin
              {mem_req, mem_we, mem_addr, mem_blen} <= {2'h2, buf_r, blen};
              bcnt_r <= blen;
            end
            else if (w3_r[utd_pkg::D3_LAST])
            begin
              fifo_commit <= last_cmt;
              fifo_ep <= dma_ep;
              {mem_req, mem_we, mem_blen} <= {2'h3, utd_pkg::WORD_BYTES};
              mem_addr <= first_r + utd_pkg::DESC_W3_OFS;
              mem_wdata <= wb_first;
              st_r <= utd_pkg::D_WBSOP;
            end
            else
              st_r <= utd_pkg::D_NEXT;
          end
          else if (mem_ack)
          begin
            fifo_wr <= 1'b1;
            fifo_ep <= dma_ep;
            fifo_data <= mem_rdata;
            fifo_nbytes <= nb;
            rem_r <= rem_r - {13'h0, nb};
            buf_r <= buf_r + {29'h0, nb};
            bcnt_r <= bcnt_r - {4'h0, nb};
            pbytes_r <= net_cut ? 11'h0 : pbytes_r + {8'h0, nb};
            fifo_commit <= net_cut;
            if (bcnt_r <= utd_pkg::WORD_BYTES)
              mem_req <= 1'b0;
          end
        utd_pkg::D_WBSOP:
          if (mem_ack)
          begin
            if (qend_cur)
            begin
              mem_addr <= desc_r + utd_pkg::DESC_W3_OFS;
              mem_wdata <= w3_r | (32'h1 << utd_pkg::D3_QEND);
              st_r <= utd_pkg::D_WBEOQ;
            end
            else
            begin
              mem_req <= 1'b0;
              st_r <= utd_pkg::D_NEXT;
            end
          end
        utd_pkg::D_WBEOQ:
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            st_r <= utd_pkg::D_NEXT;
          end
        utd_pkg::D_NEXT:
          if ((nxt_r != 32'h0) & ~w3_r[utd_pkg::D3_LAST])
          begin
            desc_r <= nxt_r;
            {mem_req, mem_we, mem_addr, mem_blen} <= {2'h2, nxt_r, utd_pkg::DESC_BYTES};
            widx_r <= 2'h0;
            st_r <= utd_pkg::D_DESC;
          end
          else
            st_r <= utd_pkg::D_IDLE;
        default:
          st_r <= utd_pkg::D_IDLE;
      endcase
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_DMA_REQ: assert property (dma_req[0] |-> $past(ctl_r[1][12]) && $past(pcnt_r[1] < cap[1]))
    else $error("dma request without fifo room or enable");
  AST_TOKEN: assert property (iss_v |-> rdy_mask[iss_ep] ##1 tok_valid && tok_ep == $past(iss_ep))
    else $error("out token for an endpoint with no ready packet");
  AST_SOF: assert property (sof_pulse |-> frm_r == 32'h0 ##1 !sof_pulse)
    else $error("start of frame pulse malformed");
  AST_NO_EP0: assert property (fifo_wr |-> fifo_ep != 3'h0 && fifo_ep <= 3'h4)
    else $error("dma wrote to endpoint 0 or beyond endpoint 4");
  AST_BURST: assert property (mem_req && !mem_we |-> mem_blen <= 7'h40 && mem_blen != 7'h0)
    else $error("read burst outside 1 to 64 bytes");
  AST_INCR: assert property (st_r == utd_pkg::D_DATA && mem_req && mem_ack
    |=> buf_r == $past(buf_r) + {29'h0, $past(nb)})
    else $error("buffer address did not advance by bytes moved");
  AST_OWNER: assert property (st_r == utd_pkg::D_WBSOP && mem_req
    |-> mem_we && !mem_wdata[29] && mem_addr == first_r + 32'hC)
    else $error("ownership write-back wrong");
  AST_QEND: assert property (st_r == utd_pkg::D_WBEOQ && mem_req |-> mem_wdata[28] && mem_we)
    else $error("queue end write-back missing flag");
  AST_HEAD: assert property (st_r == utd_pkg::D_NEXT |=> head_r[$past(ch_r)] == $past(nxt_r))
    else $error("channel head not written back");
  AST_COMMIT: assert property (st_r == utd_pkg::D_DATA && !mem_req && rem_r == 16'h0
    && w3_r[30] && !net_mode |=> fifo_commit && fifo_ep == $past(dma_ep))
    else $error("loaded packet not marked ready");

  COV_QEND: cover property (st_r == utd_pkg::D_WBEOQ && mem_ack);
  COV_NET: cover property (fifo_commit && net_mode && st_r == utd_pkg::D_DATA);
  COV_TOKEN: cover property (tok_valid ##[1:200] ep_irq != 5'h0);
  COV_DBL: cover property (pcnt_r[1] == 2'h2);
endmodule // usb_host_tx_dma_descriptor_engine

/* File: core/utd_pkg.sv */
// constants, register map and types of the host transmit dma engine
// assumes a 50 MHz system clock and a 12-bit apb byte address
package utd_pkg;
  localparam int CLK_MHZ = 50;
  localparam int FRAME_TIME_US = 1000;
  localparam int NUM_EP = 5;
  localparam int NUM_CH = 4;
  // per-endpoint window: endpoint n at byte n*32
  localparam logic [4:0] OFS_FUNC = 5'h00;
  localparam logic [4:0] OFS_TYPE = 5'h04;
  localparam logic [4:0] OFS_MAXP = 5'h08;
  localparam logic [4:0] OFS_INTV = 5'h0C;
  localparam logic [4:0] OFS_CSR = 5'h10;
  localparam logic [4:0] OFS_FIFOSZ = 5'h14;
  localparam logic [11:0] OFS_IRQ_EN = 12'h100;
  localparam logic [11:0] OFS_HEAD0 = 12'h200;
  localparam logic [11:0] OFS_MODE = 12'h210;
  localparam int FIFOSZ_DBL_BIT = 4;
  localparam int CSR_PKT_READY_BIT = 0;
  localparam int CSR_NOT_EMPTY_BIT = 1;
  localparam int CSR_ERROR_BIT = 2;
  localparam int CSR_SUPPRESS_BIT = 10;
  localparam int CSR_FORCE_TOGGLE_BIT = 11;
  localparam int CSR_DMA_EN_BIT = 12;
  localparam int CSR_MODE_BIT = 13;
  localparam logic [15:0] CSR_RW_MASK = 16'h3C00;
  localparam int TYPE_PROTO_LSB = 4;
  localparam logic [1:0] PROTO_ISO = 2'h1;
  // descriptor word 3 flags
  localparam int D3_FIRST = 31;
  localparam int D3_LAST = 30;
  localparam int D3_OWNER = 29;
  localparam int D3_QEND = 28;
  localparam logic [31:0] DESC_W3_OFS = 32'h0000000C;
  localparam logic [6:0] DESC_BYTES = 7'h10;
  localparam logic [6:0] MAX_BURST = 7'h40;
  localparam logic [6:0] WORD_BYTES = 7'h04;
  localparam logic [31:0] RST_HEAD = 32'h00000000;
  localparam logic [15:0] RST_CSR = 16'h0000;
  localparam logic [4:0] RST_FIFOSZ = 5'h00;
  localparam logic [10:0] RST_MAXP = 11'h000;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_DESC = 3'b001,
    D_DATA = 3'b010,
    D_WBSOP = 3'b011,
    D_WBEOQ = 3'b100,
    D_NEXT = 3'b101
  } dma_state_t;
endpackage

/* File: verif/tx_mem_model.sv */
// main memory holding descriptor queues and transmit buffers
// assumes byte addresses below 1024 and one word moved per ack
`timescale 1ns/100ps
module tx_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [6:0] mem_blen,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [7:0] mem [0:1023];
  logic hold = 1'b0;
  logic [9:0] a;
  logic [32:0] last_q = 33'h0;
  int n = 0;
  int nn;
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    for (int i = 0; i < 1024; i++)
      mem[i] = i[7:0];
  end
  // the engine may keep its request up and move to a new address: that is a new burst
  assign nn = ({mem_we, mem_addr} == last_q) ? n : 0;
  assign a = mem_addr[9:0] + 10'(4 * nn);
  always @(posedge clk)
  begin
    hold <= slow & ~hold;
    last_q <= {mem_we, mem_addr};
    if (mem_req && !hold && nn < (mem_we ? 1 : (mem_blen + 3) / 4))
    begin
      mem_ack <= 1'b1;
      n <= nn + 1;
      mem_rdata <= {mem[a + 10'h3], mem[a + 10'h2], mem[a + 10'h1], mem[a]};
      if (mem_we)
        {mem[a + 10'h3], mem[a + 10'h2], mem[a + 10'h1], mem[a]} <= mem_wdata;
    end
    else
    begin
      mem_ack <= 1'b0;
      // an idle bus must not look like a repeat of the last word
      mem_rdata <= ~mem_rdata;
      n <= mem_req ? nn : 0;
    end
  end
endmodule // tx_mem_model

/* File: verif/usb_host_tx_dma_descriptor_engine_tb_top.sv */
// self-checking bench: apb registers, one two-buffer dma packet, tokens, irqs
// assumes the memory model answers the dma port and the bench plays the link
`timescale 1ns/100ps
module usb_host_tx_dma_descriptor_engine_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic sent_valid = 1'b0;
  logic [2:0] sent_ep = 3'h0;
  logic sent_err = 1'b0;
  logic slow = 1'b0;
  logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, fifo_data, rdv;
  logic pready, pslverr, mem_req, mem_we, mem_ack, fifo_wr, fifo_commit;
  logic tok_valid, sof_pulse, erv;
  logic [6:0] mem_blen, tok_func_addr;
  logic [2:0] fifo_ep, fifo_nbytes, tok_ep;
  logic [3:0] dma_req;
  logic [7:0] tok_type;
  logic [4:0] ep_irq;
  logic [17:0] tok = 18'h0;
  logic big = 1'b0;
  int fail_count = 0, checked = 0, fb = 0, fs = 0, fc = 0, ic = 0, gap = 0, lgap = 0, cyc = 0;
  int n, k;
  logic [11:0] ra [10] = '{12'h000, 12'h080, 12'h020, 12'h024, 12'h028, 12'h02C, 12'h034,
    12'h050, 12'h100, 12'h300};
  logic [31:0] rw [10] = '{32'h55, 32'hFF, 32'h7F, 32'hD5, 32'hFFFF, 32'h1FF, 32'h10,
    32'h3C00, 32'h1F, 32'h1};
  logic [31:0] rx [10] = '{32'h55, 32'h7F, 32'h7F, 32'hD5, 32'h7FF, 32'hFF, 32'h10,
    32'h3C00, 32'h1F, 32'h0};

  usb_host_tx_dma_descriptor_engine #(.FRAME_CYCLES(50)) i_usb_host_tx_dma_descriptor_engine (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_blen(mem_blen), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .fifo_wr(fifo_wr),
    .fifo_ep(fifo_ep), .fifo_data(fifo_data), .fifo_nbytes(fifo_nbytes),
    .fifo_commit(fifo_commit), .dma_req(dma_req), .tok_valid(tok_valid), .tok_ep(tok_ep),
    .tok_func_addr(tok_func_addr), .tok_type(tok_type), .sent_valid(sent_valid),
    .sent_ep(sent_ep), .sent_err(sent_err), .ep_irq(ep_irq), .sof_pulse(sof_pulse));
  tx_mem_model i_tx_mem_model (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_blen(mem_blen), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  initial
  begin
    forever #10 clk = ~clk;
  end

  task print_verdict;
    $display("compares %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready ends this wait; if it never comes, only the bench timeout does
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task setw(input int a, input logic [31:0] d);
    {i_tx_mem_model.mem[a + 3], i_tx_mem_model.mem[a + 2], i_tx_mem_model.mem[a + 1],
      i_tx_mem_model.mem[a]} = d;
  endtask

  function automatic logic [31:0] getw(input int a);
    return {i_tx_mem_model.mem[a + 3], i_tx_mem_model.mem[a + 2], i_tx_mem_model.mem[a + 1],
      i_tx_mem_model.mem[a]};
  endfunction

  task sent(input logic e);
    @(posedge clk);
    sent_valid <= 1'b1;
    sent_ep <= 3'h1;
    sent_err <= e;
    @(posedge clk);
    sent_valid <= 1'b0;
    sent_err <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    gap <= sof_pulse ? 1 : gap + 1;
    if (sof_pulse)
      lgap <= gap;
    if (fifo_wr && fifo_ep == 3'h1)
    begin
      fb = fb + fifo_nbytes;
      for (int j = 0; j < fifo_nbytes; j++)
        fs = fs + fifo_data[8 * j +: 8];
    end
    fc <= fc + fifo_commit;
    ic <= ic + ep_irq[1];
    if (tok_valid)
      tok <= {tok_ep, tok_func_addr, tok_type};
    if (mem_req && mem_blen > 7'h40)
      big <= 1'b1;
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict;
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    chk(32'({pready, mem_req, tok_valid, ep_irq, dma_req}), 32'h0);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    $display("test reset done");
    for (n = 0; n < 10; n++)
    begin
      apb(1'b1, ra[n], rw[n]);
      apb(1'b0, ra[n], 32'h0);
      chk({rdv[30:0], erv}, {rx[n][30:0], n == 9});
    end
    $display("test registers done");
    apb(1'b1, 12'h030, 32'h1000);
    repeat (3) @(posedge clk);
    chk(32'(dma_req), 32'h3);
    $display("test request done");
    // one packet of two buffers, first one skips one leading byte
    setw(12'h100, 32'h110);
    setw(12'h104, 32'h200);
    setw(12'h108, 32'h00010003);
    setw(12'h10C, 32'hA0000000);
    setw(12'h110, 32'h0);
    setw(12'h114, 32'h300);
    setw(12'h118, 32'h5);
    setw(12'h11C, 32'h40000000);
    slow <= 1'b1;
    apb(1'b1, 12'h200, 32'h100);
    for (n = 0; n < 600 && getw(12'h11C) !== 32'h50000000; n++)
      @(posedge clk);
    chk(fb, 8);
    chk(fs, 16);
    chk(fc, 1);
    chk(getw(12'h10C), 32'h80000000);
    chk(getw(12'h11C), 32'h50000000);
    apb(1'b0, 12'h200, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk(rdv, 32'h1003);
    chk(32'(dma_req[0]), 32'h1);
    $display("test descriptors done");
    for (n = 0; n < 200 && tok == 18'h0; n++)
      @(posedge clk);
    chk(32'(tok), {14'h0, 3'h1, 7'h7F, 8'hD5});
    k = ic;
    sent(1'b0);
    chk(ic, k + 1);
    apb(1'b1, 12'h030, 32'h1400);
    sent(1'b0);
    chk(ic, k + 1);
    sent(1'b1);
    chk(ic, k + 2);
    $display("test link done");
    // network mode: cut every 4 bytes, the rest committed at the last buffer
    setw(12'h140, 32'h0);
    setw(12'h144, 32'h200);
    setw(12'h148, 32'h6);
    setw(12'h14C, 32'hE0000000);
    apb(1'b1, 12'h028, 32'h4);
    apb(1'b1, 12'h210, 32'h1);
    apb(1'b1, 12'h200, 32'h140);
    for (n = 0; n < 600 && getw(12'h14C) !== 32'hD0000000; n++)
      @(posedge clk);
    chk(fb, 14);
    chk(fc, 3);
    chk(getw(12'h14C), 32'hD0000000);
    chk(32'(dma_req[0]), 32'h0);
    $display("test network mode done");
    chk(lgap, 50);
    chk(32'(big), 32'h0);
    $display("test frame done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({pready, mem_req, tok_valid, ep_irq, dma_req}), 32'h0);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 12'h030, 32'h0);
    chk(rdv, 32'h0);
    $display("test mid reset done");
    print_verdict;
  end
endmodule // usb_host_tx_dma_descriptor_engine_tb_top
